// ---- rtl/asic_core.v ----
// Polled asynchronous serial controller, one channel, with baud generator.
// Assumes a host on an 8-bit bus with strobes synchronous to REF_CLK_I.
//
// Contract
// - Force-reset command equals hardware reset
// - Reset bits idle channel, mark line, outputs high
// - Generator divides source by 2*(tc+2)
// - Time constant is two host bytes
// - Times-sixteen clock for bit timing
// - Misc bit zero runs the generator
// - Receive control bit zero enables receiver
// - Transmit control bit three enables transmitter
// - Five to eight bits, 1/1.5/2 stops
// - Transmit least significant bit first
// - Parameter 4CH: async x16, two stops
// - Routing 56H: generator clocks, drives pin
// - Misc 10H: pin source, stopped, loopback
// - Loopback feeds transmitter into receiver
// - Coding 00H selects NRZ
// - Master control 00H raises no interrupt
`timescale 1ns/10ps
`include "asic_consts.vh"
module asic_core
(
  input wire REF_CLK_I,
  input wire RSTN_I,
  input wire [7:0] DATA_I,
  input wire RDN_I,
  input wire WRN_I,
  input wire CEN_I,
  input wire DC_I,
  input wire RXTX_CLK_PIN_I,
  input wire BIDIR_CLK_PIN_I,
  input wire RXD_I,
  input wire INT_ENABLE_IN_I,
  output reg [7:0] DATA_O,
  output reg DATA_OEN_O,
  output reg TXD_O,
  output reg BIDIR_CLK_PIN_O,
  output reg BIDIR_CLK_OEN_O,
  output reg DTRN_O,
  output reg RTSN_O,
  output reg INTN_O,
  output reg BUSY_O
);
  reg [7:0] master_int_ctrl_reg;
  reg [7:0] txrx_param_reg;
  reg [7:0] int_dma_enable_reg;
  reg [7:0] int_vector_reg;
  reg [7:0] rx_ctrl_reg;
  reg [7:0] tx_ctrl_reg;
  reg [7:0] sync_char_low_reg;
  reg [7:0] sync_char_high_reg;
  reg [7:0] coding_ctrl_reg;
  reg [7:0] clock_routing_reg;
  reg [7:0] time_const_low_reg;
  reg [7:0] time_const_high_reg;
  reg [7:0] misc_ctrl_reg;
  reg [7:0] ext_status_int_en_reg;
  reg [3:0] ptr_reg;
  reg soft_rst_reg;
  reg [7:0] rec_reg;
  reg [1:0] pin_a_sync_reg;
  reg [1:0] pin_b_sync_reg;
  reg [1:0] rxd_sync_reg;
  reg [1:0] rd_sync_reg;
  reg [1:0] wr_sync_reg;
  reg [1:0] ce_sync_reg;
  reg [1:0] dc_sync_reg;
  reg [1:0] iei_sync_reg;
  reg pin_a_d_reg;
  reg pin_b_d_reg;
  reg rd_d_reg;
  reg wr_d_reg;
  reg [7:0] data_meta_reg;
  reg [7:0] data_sync_reg;
  wire rst_n;
  wire wr_stb;
  wire rd_stb;
  wire src_tick;
  wire brg_out;
  wire brg_edge;
  wire tick16;
  wire [7:0] status;
  wire tx_empty;
  wire rx_avail;
  wire [7:0] rx_data;
  wire txd_int;
  wire rxd_mux;
  wire chan_rst;
  wire int_pend;
  wire [7:0] rd_word;
  // Command reset goes through a flop so no comb path feeds reset
  assign rst_n = RSTN_I & ~soft_rst_reg;
  assign wr_stb = wr_d_reg & ~wr_sync_reg[1] & ~ce_sync_reg[1];
  assign rd_stb = rd_d_reg & ~rd_sync_reg[1] & ~ce_sync_reg[1];
  assign chan_rst = master_int_ctrl_reg[`ASIC_MIC_RSTA_BIT] |
    master_int_ctrl_reg[`ASIC_MIC_RSTB_BIT];
  // Generator source: pin (bit 1 clear) or the core clock
  assign src_tick = misc_ctrl_reg[`ASIC_MISC_BRG_SRC_BIT] ? 1'b1 :
    (pin_a_sync_reg[1] & ~pin_a_d_reg);
  // Bit clock source from routing bits 4:3 only, bits 6:5 are ignored; only the
  // generator and the pins are honoured, one shared clock for both
  assign tick16 = (clock_routing_reg[4:3] == 2'b10) ? brg_edge :
    (clock_routing_reg[4:3] == 2'b01) ?
    (pin_b_sync_reg[1] & ~pin_b_d_reg) :
    (pin_a_sync_reg[1] & ~pin_a_d_reg);
  assign rxd_mux = misc_ctrl_reg[`ASIC_MISC_LOOP_BIT] ? txd_int :
    rxd_sync_reg[1];
  assign status = {5'b00000, tx_empty, 1'b0, rx_avail};
  assign int_pend = master_int_ctrl_reg[`ASIC_MIC_MIE_BIT] &
    iei_sync_reg[1] & ~chan_rst &
    ((int_dma_enable_reg[1] & tx_empty) |
    (int_dma_enable_reg[4] & rx_avail));
  // Unlisted pointers read back the status byte
  assign rd_word = dc_sync_reg[1] ? rx_data :
    (ptr_reg == `ASIC_PTR_TCL) ? time_const_low_reg :
    (ptr_reg == `ASIC_PTR_TCH) ? time_const_high_reg :
    (ptr_reg == `ASIC_PTR_EXTIE) ? ext_status_int_en_reg :
    (ptr_reg == `ASIC_PTR_VEC) ? int_vector_reg : status;
  always @(posedge REF_CLK_I or negedge RSTN_I)
  begin
    if (!RSTN_I)
    begin
      pin_a_sync_reg <= 2'b00;
      // Clock pin idles high, so reset cannot fake a rising edge
      pin_b_sync_reg <= 2'b11;
      rxd_sync_reg <= 2'b11;
      rd_sync_reg <= 2'b11;
      wr_sync_reg <= 2'b11;
      ce_sync_reg <= 2'b11;
      dc_sync_reg <= 2'b00;
      iei_sync_reg <= 2'b11;
      pin_a_d_reg <= 1'b0;
      pin_b_d_reg <= 1'b1;
      rd_d_reg <= 1'b1;
      wr_d_reg <= 1'b1;
      data_meta_reg <= 8'h00;
      data_sync_reg <= 8'h00;
    end
    else
    begin
      pin_a_sync_reg <= {pin_a_sync_reg[0], RXTX_CLK_PIN_I};
      pin_b_sync_reg <= {pin_b_sync_reg[0], BIDIR_CLK_PIN_I};
      rxd_sync_reg <= {rxd_sync_reg[0], RXD_I};
      rd_sync_reg <= {rd_sync_reg[0], RDN_I};
      wr_sync_reg <= {wr_sync_reg[0], WRN_I};
      ce_sync_reg <= {ce_sync_reg[0], CEN_I};
      dc_sync_reg <= {dc_sync_reg[0], DC_I};
      iei_sync_reg <= {iei_sync_reg[0], INT_ENABLE_IN_I};
      pin_a_d_reg <= pin_a_sync_reg[1];
      pin_b_d_reg <= pin_b_sync_reg[1];
      rd_d_reg <= rd_sync_reg[1];
      wr_d_reg <= wr_sync_reg[1];
      // Two stages like the strobes; the host holds data across them
      data_meta_reg <= DATA_I;
      data_sync_reg <= data_meta_reg;
    end
  end
  always @(posedge REF_CLK_I or negedge RSTN_I)
  begin
    if (!RSTN_I)
    begin
      soft_rst_reg <= 1'b0;
    end
    else
    begin
      soft_rst_reg <= wr_stb & ~dc_sync_reg[1] &
        (ptr_reg == `ASIC_PTR_MIC) &
        (data_sync_reg == `ASIC_MIC_FORCE_RST);
    end
  end
  always @(posedge REF_CLK_I or negedge rst_n)
  begin
    if (!rst_n)
    begin
      master_int_ctrl_reg <= `ASIC_RV_MIC;
      txrx_param_reg <= `ASIC_RV_PARAM;
      int_dma_enable_reg <= 8'h00;
      int_vector_reg <= 8'h00;
      rx_ctrl_reg <= 8'h00;
      tx_ctrl_reg <= 8'h00;
      sync_char_low_reg <= 8'h00;
      sync_char_high_reg <= 8'h00;
      coding_ctrl_reg <= 8'h00;
      clock_routing_reg <= `ASIC_RV_CLK;
      time_const_low_reg <= 8'h00;
      time_const_high_reg <= 8'h00;
      misc_ctrl_reg <= `ASIC_RV_MISC;
      ext_status_int_en_reg <= `ASIC_RV_EXTIE;
      ptr_reg <= 4'h0;
    end
    else if (wr_stb && !dc_sync_reg[1])
    begin
      ptr_reg <= 4'h0;
      case (ptr_reg)
        `ASIC_PTR_CMD: ptr_reg <= data_sync_reg[3:0];
        `ASIC_PTR_MIC: master_int_ctrl_reg <= data_sync_reg;
        `ASIC_PTR_PARAM: txrx_param_reg <= data_sync_reg;
        `ASIC_PTR_INTEN: int_dma_enable_reg <= data_sync_reg;
        `ASIC_PTR_VEC: int_vector_reg <= data_sync_reg;
        `ASIC_PTR_RXC: rx_ctrl_reg <= data_sync_reg;
        `ASIC_PTR_TXC: tx_ctrl_reg <= data_sync_reg;
        `ASIC_PTR_SYNL: sync_char_low_reg <= data_sync_reg;
        `ASIC_PTR_SYNH: sync_char_high_reg <= data_sync_reg;
        `ASIC_PTR_CODE: coding_ctrl_reg <= data_sync_reg;
        `ASIC_PTR_CLK: clock_routing_reg <= data_sync_reg;
        `ASIC_PTR_TCL: time_const_low_reg <= data_sync_reg;
        `ASIC_PTR_TCH: time_const_high_reg <= data_sync_reg;
        `ASIC_PTR_MISC: misc_ctrl_reg <= data_sync_reg;
        `ASIC_PTR_EXTIE: ext_status_int_en_reg <= data_sync_reg;
        default: ptr_reg <= 4'h0;
      endcase
    end
    else if (rd_stb && !dc_sync_reg[1])
    begin
      ptr_reg <= 4'h0;
    end
  end
  asic_brg #(.W(16)) u_brg
  (
    .clk_i(REF_CLK_I),
    .rstn_i(rst_n),
    .run_i(misc_ctrl_reg[`ASIC_MISC_BRG_EN_BIT]),
    .src_tick_i(src_tick),
    .tc_i({time_const_high_reg, time_const_low_reg}),
    .out_o(brg_out),
    .edge_o(brg_edge)
  );
  // Only the x16 mode is built; bits 7:6 of the parameter are ignored
  asic_txrx u_txrx
  (
    .clk_i(REF_CLK_I),
    .rstn_i(rst_n),
    .tick_i(tick16),
    .tx_en_i(tx_ctrl_reg[`ASIC_TXC_EN_BIT] & ~chan_rst),
    .rx_en_i(rx_ctrl_reg[`ASIC_RXC_EN_BIT] & ~chan_rst),
    .bits_i(tx_ctrl_reg[6:5]),
    .stop_i(txrx_param_reg[3:2]),
    .load_i(wr_stb & dc_sync_reg[1]),
    .load_data_i(data_sync_reg),
    .rxd_i(rxd_mux),
    .rd_ack_i(rd_stb & dc_sync_reg[1]),
    .txd_o(txd_int),
    .tx_empty_o(tx_empty),
    .rx_avail_o(rx_avail),
    .rx_data_o(rx_data)
  );
  always @(posedge REF_CLK_I or negedge rst_n)
  begin
    if (!rst_n)
    begin
      // Soft reset clears the read latch too, as the pin reset does
      DATA_O <= 8'h00;
      DATA_OEN_O <= 1'b1;
      TXD_O <= 1'b1;
      BIDIR_CLK_PIN_O <= 1'b0;
      BIDIR_CLK_OEN_O <= 1'b1;
      DTRN_O <= 1'b1;
      RTSN_O <= 1'b1;
      INTN_O <= 1'b1;
      BUSY_O <= 1'b1;
      rec_reg <= `ASIC_RST_RECOVERY;
    end
    else
    begin
      // Loopback keeps the line marking while echoing internally
      TXD_O <= (misc_ctrl_reg[`ASIC_MISC_LOOP_BIT] | chan_rst) ? 1'b1 :
        txd_int;
      DTRN_O <= chan_rst ? 1'b1 : ~tx_ctrl_reg[7];
      RTSN_O <= chan_rst ? 1'b1 : ~tx_ctrl_reg[1];
      INTN_O <= ~int_pend;
      BIDIR_CLK_OEN_O <= ~clock_routing_reg[2];
      BIDIR_CLK_PIN_O <= (clock_routing_reg[1:0] == 2'b10) ? brg_out :
        tick16;
      DATA_OEN_O <= rd_sync_reg[1] | ce_sync_reg[1];
      if (rd_stb)
      begin
        DATA_O <= rd_word;
      end
      // Busy flag lets a host or checker see the recovery window
      if (rd_stb || wr_stb)
      begin
        rec_reg <= `ASIC_CYC_RECOVERY;
      end
      else if (rec_reg != 8'h00)
      begin
        rec_reg <= rec_reg - 8'h01;
      end
      BUSY_O <= (rec_reg > 8'h01) | rd_stb | wr_stb;
    end
  end
endmodule // asic_core

// ---- rtl/asic_consts.vh ----
// Constants for the asynchronous serial controller core.
// Assumes inclusion by bare name from the rtl directory.
`ifndef ASIC_CONSTS_VH
`define ASIC_CONSTS_VH
`define ASIC_PTR_MIC 4'd9
`define ASIC_PTR_CMD 4'd0
`define ASIC_PTR_PARAM 4'd4
`define ASIC_PTR_INTEN 4'd1
`define ASIC_PTR_VEC 4'd2
`define ASIC_PTR_RXC 4'd3
`define ASIC_PTR_TXC 4'd5
`define ASIC_PTR_SYNL 4'd6
`define ASIC_PTR_SYNH 4'd7
`define ASIC_PTR_CODE 4'd10
`define ASIC_PTR_CLK 4'd11
`define ASIC_PTR_TCL 4'd12
`define ASIC_PTR_TCH 4'd13
`define ASIC_PTR_MISC 4'd14
`define ASIC_PTR_EXTIE 4'd15
`define ASIC_MIC_FORCE_RST 8'hc0
`define ASIC_RV_MIC 8'hc0
`define ASIC_RV_PARAM 8'h04
`define ASIC_RV_CLK 8'h08
`define ASIC_RV_MISC 8'h30
`define ASIC_RV_EXTIE 8'hf8
`define ASIC_MIC_MIE_BIT 3
`define ASIC_MIC_RSTA_BIT 7
`define ASIC_MIC_RSTB_BIT 6
`define ASIC_RXC_EN_BIT 0
`define ASIC_TXC_EN_BIT 3
`define ASIC_MISC_BRG_EN_BIT 0
`define ASIC_MISC_BRG_SRC_BIT 1
`define ASIC_MISC_LOOP_BIT 4
`define ASIC_ST_RXAV_BIT 0
`define ASIC_ST_TXE_BIT 2
`define ASIC_RST_RECOVERY 8'd11
`define ASIC_CYC_RECOVERY 8'd6
`endif

// ---- rtl/asic_brg.v ----
// Baud-rate generator: divides its source by 2*(tc+2).
// Assumes src_tick_i is a one-cycle tick on the core clock.
`timescale 1ns/10ps
module asic_brg
#(
  parameter W = 16
)
(
  input wire clk_i,
  input wire rstn_i,
  input wire run_i,
  input wire src_tick_i,
  input wire [W-1:0] tc_i,
  output reg out_o,
  output reg edge_o
);
  reg [W:0] cnt_reg;
  // Half period is tc+2 source ticks, so output = src/(2*(tc+2))
  always @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      cnt_reg <= 17'h00000;
      out_o <= 1'b0;
      edge_o <= 1'b0;
    end
    else
    begin
      edge_o <= 1'b0;
      if (!run_i)
      begin
        cnt_reg <= {1'b0, tc_i} + 17'h00001;
      end
      else if (src_tick_i)
      begin
        if (cnt_reg == 17'h00000)
        begin
          cnt_reg <= {1'b0, tc_i} + 17'h00001;
          out_o <= ~out_o;
          edge_o <= ~out_o;
        end
        else
        begin
          cnt_reg <= cnt_reg - 17'h00001;
        end
      end
    end
  end
endmodule // asic_brg

// ---- rtl/asic_txrx.v ----
// Async transmitter and receiver on a x16 bit clock tick.
// Assumes tick_i is a one-cycle pulse at 16 times the bit rate.
`timescale 1ns/10ps
module asic_txrx
(
  input wire clk_i,
  input wire rstn_i,
  input wire tick_i,
  input wire tx_en_i,
  input wire rx_en_i,
  input wire [1:0] bits_i,
  input wire [1:0] stop_i,
  input wire load_i,
  input wire [7:0] load_data_i,
  input wire rxd_i,
  input wire rd_ack_i,
  output reg txd_o,
  output reg tx_empty_o,
  output reg rx_avail_o,
  output reg [7:0] rx_data_o
);
  reg [7:0] tbuf_reg;
  reg [10:0] tsh_reg;
  reg [3:0] tbit_reg;
  reg [5:0] tsub_reg;
  reg tbusy_reg;
  reg [3:0] rsub_reg;
  reg [3:0] rbit_reg;
  reg rbusy_reg;
  reg [7:0] rsh_reg;
  wire [3:0] nbits;
  wire [5:0] stop_ticks;
  assign nbits = {2'b00, bits_i} + 4'd5;
  assign stop_ticks = (stop_i == 2'd1) ? 6'd16 :
    (stop_i == 2'd2) ? 6'd24 : 6'd32;
  always @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      tbuf_reg <= 8'h00;
      tsh_reg <= 11'h7ff;
      tbit_reg <= 4'h0;
      tsub_reg <= 6'h00;
      tbusy_reg <= 1'b0;
      tx_empty_o <= 1'b1;
      txd_o <= 1'b1;
    end
    else
    begin
      if (load_i)
      begin
        tbuf_reg <= load_data_i;
        tx_empty_o <= 1'b0;
      end
      if (!tx_en_i)
      begin
        tbusy_reg <= 1'b0;
        txd_o <= 1'b1;
      end
      else if (!tbusy_reg && !tx_empty_o && !load_i)
      begin
        tsh_reg <= {3'b111, tbuf_reg};
        tbusy_reg <= 1'b1;
        tx_empty_o <= 1'b1;
        tbit_reg <= 4'h0;
        tsub_reg <= 6'h00;
        txd_o <= 1'b0;
      end
      else if (tbusy_reg && tick_i)
      begin
        tsub_reg <= tsub_reg + 6'h01;
        if (tbit_reg > nbits && tsub_reg == stop_ticks - 6'h01)
        begin
          tbusy_reg <= 1'b0;
        end
        else if (tbit_reg <= nbits && tsub_reg == 6'h0f)
        begin
          tsub_reg <= 6'h00;
          tbit_reg <= tbit_reg + 4'h1;
          txd_o <= (tbit_reg < nbits) ? tsh_reg[0] : 1'b1;
          tsh_reg <= {1'b1, tsh_reg[10:1]};
        end
      end
    end
  end
  always @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      rsub_reg <= 4'h0;
      rbit_reg <= 4'h0;
      rbusy_reg <= 1'b0;
      rsh_reg <= 8'h00;
      rx_avail_o <= 1'b0;
      rx_data_o <= 8'h00;
    end
    else
    begin
      if (rd_ack_i)
      begin
        rx_avail_o <= 1'b0;
      end
      if (!rx_en_i)
      begin
        rbusy_reg <= 1'b0;
      end
      else if (tick_i)
      begin
        if (!rbusy_reg)
        begin
          if (!rxd_i)
          begin
            rbusy_reg <= 1'b1;
            rsub_reg <= 4'h0;
            rbit_reg <= 4'h0;
          end
        end
        else
        begin
          rsub_reg <= rsub_reg + 4'h1;
          // Sample mid-bit, eight ticks after each boundary
          if (rsub_reg == 4'h7)
          begin
            if (rbit_reg == 4'h0 && rxd_i)
            begin
              rbusy_reg <= 1'b0;
            end
            else if (rbit_reg == nbits + 4'h1)
            begin
              rbusy_reg <= 1'b0;
              rx_data_o <= rsh_reg >> (4'd8 - nbits);
              rx_avail_o <= 1'b1;
            end
            else if (rbit_reg != 4'h0)
            begin
              rsh_reg <= {rxd_i, rsh_reg[7:1]};
            end
            rbit_reg <= rbit_reg + 4'h1;
          end
        end
      end
    end
  end
endmodule // asic_txrx

// ---- tb/asic_core_properties.sv ----
// Checker for the serial core, watching only its top-level ports.
// Assumes one clock domain and the host strobes held five clocks.
`timescale 1ns/10ps
module asic_core_properties
(
  input wire REF_CLK_I,
  input wire RSTN_I,
  input wire RDN_I,
  input wire WRN_I,
  input wire CEN_I,
  input wire INT_ENABLE_IN_I,
  input wire [7:0] DATA_O,
  input wire DATA_OEN_O,
  input wire TXD_O,
  input wire BIDIR_CLK_PIN_O,
  input wire BIDIR_CLK_OEN_O,
  input wire DTRN_O,
  input wire RTSN_O,
  input wire INTN_O,
  input wire BUSY_O
);
  default clocking cb @(posedge REF_CLK_I);
  endclocking
  default disable iff (!RSTN_I);
  property p_rst_idle;
    $rose(RSTN_I) |-> (TXD_O && DTRN_O && RTSN_O && INTN_O) [*8];
  endproperty
  a_rst_idle: assert property (p_rst_idle)
    else $error("outputs not idle after reset");
  property p_rst_busy;
    $rose(RSTN_I) |-> BUSY_O [*8];
  endproperty
  a_rst_busy: assert property (p_rst_busy)
    else $error("recovery flag short after reset");
  property p_busy_hold;
    $rose(BUSY_O) |-> BUSY_O [*5];
  endproperty
  a_busy_hold: assert property (p_busy_hold)
    else $error("recovery window too short");
  property p_busy_end;
    $rose(BUSY_O) |-> ##[1:20] !BUSY_O;
  endproperty
  a_busy_end: assert property (p_busy_end)
    else $error("recovery window never ends");
  property p_oen_rd;
    $fell(DATA_OEN_O) |-> $past(!RDN_I && !CEN_I, 2);
  endproperty
  a_oen_rd: assert property (p_oen_rd)
    else $error("data bus driven without read");
  property p_oen_idle;
    RDN_I [*6] |-> DATA_OEN_O;
  endproperty
  a_oen_idle: assert property (p_oen_idle)
    else $error("data bus driven while idle");
  property p_data_rd;
    $changed(DATA_O) |-> $past(!RDN_I) || (DATA_O == 8'h00 && BUSY_O);
  endproperty
  a_data_rd: assert property (p_data_rd)
    else $error("read data changed outside read");
  property p_clk_oen;
    $fell(BIDIR_CLK_OEN_O) |-> $past(!WRN_I, 2);
  endproperty
  a_clk_oen: assert property (p_clk_oen)
    else $error("clock pin driven without write");
  property p_brg_min;
    $changed(BIDIR_CLK_PIN_O) |=> $stable(BIDIR_CLK_PIN_O) [*3];
  endproperty
  a_brg_min: assert property (p_brg_min)
    else $error("generator half period too short");
  property p_int_quiet;
    !INT_ENABLE_IN_I [*4] |-> INTN_O;
  endproperty
  a_int_quiet: assert property (p_int_quiet)
    else $error("interrupt raised while blocked");
endmodule // asic_core_properties
bind asic_core asic_core_properties u_props
(
  .REF_CLK_I(REF_CLK_I),
  .RSTN_I(RSTN_I),
  .RDN_I(RDN_I),
  .WRN_I(WRN_I),
  .CEN_I(CEN_I),
  .INT_ENABLE_IN_I(INT_ENABLE_IN_I),
  .DATA_O(DATA_O),
  .DATA_OEN_O(DATA_OEN_O),
  .TXD_O(TXD_O),
  .BIDIR_CLK_PIN_O(BIDIR_CLK_PIN_O),
  .BIDIR_CLK_OEN_O(BIDIR_CLK_OEN_O),
  .DTRN_O(DTRN_O),
  .RTSN_O(RTSN_O),
  .INTN_O(INTN_O),
  .BUSY_O(BUSY_O)
);

// ---- tb/asic_host_model.sv ----
// Host CPU model driving the byte bus with spaced strobes.
// Assumes the core samples strobes on the core clock.
`timescale 1ns/10ps
module asic_host_model
(
  input wire clk_i,
  input wire [7:0] rd_data_i,
  output reg [7:0] wr_data_o,
  output reg rdn_o,
  output reg wrn_o,
  output reg cen_o,
  output reg dc_o
);
  initial
  begin
    wr_data_o = 8'h00;
    rdn_o = 1'b1;
    wrn_o = 1'b1;
    cen_o = 1'b1;
    dc_o = 1'b0;
  end
  task acc(input reg dc, input reg rd, input reg [7:0] d,
    output reg [7:0] q);
    begin
      @(negedge clk_i);
      cen_o = 1'b0;
      dc_o = dc;
      wr_data_o = d;
      rdn_o = !rd;
      wrn_o = rd;
      repeat (5) @(negedge clk_i);
      q = rd_data_i;
      cen_o = 1'b1;
      rdn_o = 1'b1;
      wrn_o = 1'b1;
      // Released bus shows the inverse so a stale byte never matches
      wr_data_o = ~d;
      repeat (5) @(negedge clk_i);
    end
  endtask
  task reg_wr(input reg [3:0] p, input reg [7:0] v);
    reg [7:0] dm;
    begin
      acc(1'b0, 1'b0, {4'h0, p}, dm);
      acc(1'b0, 1'b0, v, dm);
    end
  endtask
  task reg_rd(input reg [3:0] p, output reg [7:0] q);
    begin
      if (p != 4'h0)
        acc(1'b0, 1'b0, {4'h0, p}, q);
      acc(1'b0, 1'b1, 8'h00, q);
    end
  endtask
  // Ext status interrupts stay off, so no double reset command
  task settle;
    repeat (20) @(negedge clk_i);
  endtask
endmodule // asic_host_model

// ---- tb/tb.sv ----
// Bench for the polled serial core: init, generator, loopback bytes.
// Assumes the host model starts every access eleven clocks after the last.
`timescale 1ns/10ps
`define CHK(n, e, g) \
  begin \
    samples_checked = samples_checked + 1; \
    if ((g) !== (e)) \
    begin \
      miscompares = miscompares + 1; \
      $display("unexpected %s exp %h got %h", n, e, g); \
    end \
  end
module tb;
  reg ref_clk = 1'b0;
  reg rstn = 1'b0;
  reg rxtx_clk = 1'b0;
  reg int_en_in = 1'b1;
  wire [7:0] wdat, rdat;
  wire rdn, wrn, cen, dc, data_oen, txd, bclk, bclk_oen, dtrn, rtsn, intn;
  wire busy;
  integer miscompares = 0;
  integer samples_checked = 0;
  integer i, n, k;
  reg [7:0] q, b, tc, m;
  reg [95:0] vals;
  reg prev;
  reg [7:0] exp_q [$];
  localparam [47:0] PTRS = 48'h4359abcdee35;
  asic_core dut
  (
    .REF_CLK_I(ref_clk),
    .RSTN_I(rstn),
    .DATA_I(wdat),
    .RDN_I(rdn),
    .WRN_I(wrn),
    .CEN_I(cen),
    .DC_I(dc),
    .RXTX_CLK_PIN_I(rxtx_clk),
    .BIDIR_CLK_PIN_I(1'b1),
    .RXD_I(1'b1),
    .INT_ENABLE_IN_I(int_en_in),
    .DATA_O(rdat),
    .DATA_OEN_O(data_oen),
    .TXD_O(txd),
    .BIDIR_CLK_PIN_O(bclk),
    .BIDIR_CLK_OEN_O(bclk_oen),
    .DTRN_O(dtrn),
    .RTSN_O(rtsn),
    .INTN_O(intn),
    .BUSY_O(busy)
  );
  asic_host_model host
  (
    .clk_i(ref_clk),
    .rd_data_i(rdat),
    .wr_data_o(wdat),
    .rdn_o(rdn),
    .wrn_o(wrn),
    .cen_o(cen),
    .dc_o(dc)
  );
  initial
  begin
    forever #50 ref_clk = ~ref_clk;
  end
  // Baud source crystal runs free, one rising edge every two clocks
  always @(negedge ref_clk)
    rxtx_clk <= ~rxtx_clk;
  task complete_run;
    begin
      if (miscompares == 0 && samples_checked > 0)
        $display("All tests passed");
      else
        $display("Some tests failed");
      $finish;
    end
  endtask
  task poll(input integer bn);
    begin
      q = 8'h00;
      for (k = 0; k < 600 && q[bn] !== 1'b1; k = k + 1)
        host.reg_rd(4'h0, q);
      `CHK("poll bit", 1'b1, q[bn])
    end
  endtask
  initial
  begin
    repeat (40000) @(posedge ref_clk);
    miscompares = miscompares + 1;
    complete_run;
  end
  initial
  begin
    n = $urandom(29);
    tc = $urandom_range(3, 0);
    repeat (16) @(negedge ref_clk);
    rstn = 1'b1;
    host.settle;
    `CHK("busy", 1'b0, busy)
    `CHK("idle outs", 4'hf, {txd, dtrn, rtsn, intn})
    host.reg_rd(4'h0, q);
    `CHK("status", 2'b10, {q[2], q[0]})
    host.reg_wr(4'hf, 8'h00);
    host.reg_wr(4'h9, 8'hc0);
    host.settle;
    host.reg_rd(4'hf, q);
    `CHK("ext ie after force", 8'hf8, q)
    vals = {32'h4cc06000, 16'h0056, tc, 40'h001011c168};
    for (i = 0; i < 12; i = i + 1)
      host.reg_wr(PTRS[44-4*i +: 4], vals[88-8*i +: 8]);
    host.reg_rd(4'hc, b);
    host.reg_rd(4'hd, q);
    `CHK("time const", {8'h00, tc}, {q, b})
    `CHK("clk pin oen", 1'b0, bclk_oen)
    n = 0;
    i = 0;
    prev = 1'b1;
    while (i < 2 && n < 500)
    begin
      @(negedge ref_clk);
      if (bclk && !prev)
        i = i + 1;
      if (i == 1)
        n = n + 1;
      prev = bclk;
    end
    `CHK("brg period", 4 * (tc + 2), n)
    // Each byte uses a new length; 8 bits last to cover the full byte
    for (i = 0; i < 4; i = i + 1)
    begin
      poll(2);
      host.reg_wr(4'h5, {1'b0, i[1:0], 5'h08});
      b = $urandom;
      exp_q.push_back(b);
      host.acc(1'b1, 1'b0, b, q);
      poll(0);
      host.acc(1'b1, 1'b1, 8'h00, q);
      m = 8'hff >> (3 - i);
      b = exp_q.pop_front();
      `CHK("rx byte", b & m, q & m)
      `CHK("loop mark", 1'b1, txd)
    end
    host.reg_wr(4'h1, 8'h12);
    `CHK("no int", 1'b1, intn)
    int_en_in = 1'b0;
    repeat (4) @(negedge ref_clk);
    int_en_in = 1'b1;
    host.reg_wr(4'h5, 8'hea);
    `CHK("modem on", 2'b00, {dtrn, rtsn})
    rstn = 1'b0;
    repeat (3) @(negedge ref_clk);
    `CHK("reset outs", 3'b111, {txd, dtrn, rtsn})
    rstn = 1'b1;
    host.settle;
    complete_run;
  end
endmodule // tb
